// File: dpc_host_model.sv
// Host controller model that drives one port's pins of the dual-port RAM.
// Assumes one caller at a time and that pins are sampled on core_clk.
`timescale 1ns/1ps
`default_nettype none
module dpc_host_model (
  input  wire logic             core_clk,
  output dpc_pkg::dpc_host_in_t pins
);
  // Idle pins: port deselected, strobes off, data lines toggled
  function automatic dpc_pkg::dpc_host_in_t idle(dpc_pkg::dpc_host_in_t v);
    idle = v;
    idle.chip_select_low_active   = 1'b1;
    idle.chip_select_high_active  = 1'b0;
    idle.address_load_strobe_n    = 1'b1;
    idle.counter_advance_enable_n = 1'b1;
    idle.wdata                    = ~v.wdata;
  endfunction : idle
  // One access for one clock, then back to idle
  task automatic req(input dpc_pkg::dpc_host_in_t v);
    @(posedge core_clk);
    pins <= v;
    @(posedge core_clk);
    pins <= idle(v);
  endtask : req
  initial pins = idle('1);
endmodule : dpc_host_model
`default_nettype wire

// File: dpc_pkg.sv
// Shared constants and carriers for the dual-port RAM port control, plus
// the two-flop synchroniser that every host pin passes through.
// Assumes one core clock; host pins arrive asynchronously to it.
`timescale 1ns/1ps
`default_nettype none

package dpc_pkg;
  localparam int PORTS     = 2;
  localparam int DATA_W    = 72;
  localparam int LANES     = 8;
  localparam int LANE_W    = DATA_W / LANES;
  localparam int ADDR_MAX  = 18;
  localparam int PORT_LEFT  = 0;
  localparam int PORT_RIGHT = 1;

  // Mailbox distance below the top address, per owning port
  localparam logic [ADDR_MAX-1:0] MBOX_RIGHT_OFS = 18'h00000;
  localparam logic [ADDR_MAX-1:0] MBOX_LEFT_OFS  = 18'h00001;

  // Reset values
  localparam logic [ADDR_MAX-1:0] CNT_RST  = 18'h00000;
  localparam logic [ADDR_MAX-1:0] MASK_RST = 18'h3ffff;
  localparam logic                FLAG_IDLE = 1'b1;

  // Ready wait after clear while the alignment loop settles
  localparam int CLK_MHZ        = 125;
  localparam int READY_WAIT_NS  = 1000;
  localparam int READY_WAIT_CYC = (READY_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int RDY_W          = 8;

  typedef struct packed {
    logic [ADDR_MAX-1:0] addr;
    logic [LANES-1:0]    byte_lane_enable_n;
    logic                chip_select_low_active;
    logic                chip_select_high_active;
    logic                read_not_write;
    logic                output_enable_n;
    logic                address_load_strobe_n;
    logic                counter_advance_enable_n;
    logic                counter_clear_n;
    logic                counter_or_mask_select;
    logic                wrap_mode_select;
    logic                flow_through_select;
    logic                slow_clock_select_n;
    logic [DATA_W-1:0]   wdata;
  } dpc_host_in_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              dq_oe_n;
    logic              busy;
    logic              mailbox_flag_n;
    logic              counter_rollover_flag_n;
    logic              ready;
    logic              clock_align_enable;
  } dpc_host_out_t;

  typedef struct packed {
    logic [ADDR_MAX-1:0] cnt;
    logic [ADDR_MAX-1:0] mask;
    logic [ADDR_MAX-1:0] mirror;
    logic                roll_n;
    logic                mbox_n;
    logic                busy;
    logic                ready;
    logic [RDY_W-1:0]    rdy_cnt;
    logic [DATA_W-1:0]   rd1;
    logic                rd1_vld;
    logic [DATA_W-1:0]   rout;
    logic                rout_vld;
    logic                dq_oe_n;
    logic                align_en;
  } dpc_port_st_t;

  typedef struct packed {
    dpc_port_st_t [PORTS-1:0] p;
  } dpc_state_t;
endpackage : dpc_pkg

// Two-flop synchroniser for a bundle of level inputs
module dpc_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // First flop feeds only the second
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : dpc_sync

`default_nettype wire

// File: dpc_props.sv
// Checker on the ports of the dual-port RAM port control.
// Assumes pins take two sync flops plus one logic edge to act.
`timescale 1ns/1ps
`default_nettype none
module dpc_props #(
  parameter int ADDR_W = 18
) (
  input wire logic                  core_clk,
  input wire logic                  nrst,
  input wire logic                  master_clear_n,
  input wire dpc_pkg::dpc_host_in_t host_in [dpc_pkg::PORTS],
  input wire logic                  host_out_rdata_valid,
  input wire dpc_pkg::dpc_host_out_t host_out [dpc_pkg::PORTS]
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [3:0] settle_q;
  logic       ok;
  // Cycles since reset or master clear, so pin history is valid
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) settle_q <= 4'h0;
    else if (!master_clear_n) settle_q <= 4'h0;
    else if (settle_q != 4'hf) settle_q <= settle_q + 4'h1;
  end
  assign ok = settle_q > 4'h6;
  busy_pair_a: assert property (host_out[0].busy == host_out[1].busy)
    else $error("busy differs between ports");
  sel_busy_a: assert property ($rose(host_out[0].busy) && ok |->
    !$past(host_in[0].chip_select_low_active, 3) &&
    $past(host_in[0].chip_select_high_active, 3)) else $error("busy unsel");
  oe_gate_a: assert property (!host_out[0].dq_oe_n |->
    !$past(host_in[0].output_enable_n, 3) ||
    !$past(host_in[0].output_enable_n, 4)) else $error("data without oe");
  mbox_set_a: assert property ($fell(host_out[1].mailbox_flag_n) && ok |->
    !$past(host_in[0].read_not_write, 3) &&
    $past(host_in[0].byte_lane_enable_n, 3) != 8'hff) else $error("flag set");
  mbox_clear_a: assert property ($rose(host_out[1].mailbox_flag_n) && ok
    |-> $past(host_in[1].read_not_write, 3)) else $error("flag cleared");
  roll_fall_a: assert property ($fell(host_out[0].counter_rollover_flag_n)
    && ok |-> !$past(host_in[0].counter_advance_enable_n, 3) &&
    $past(host_in[0].address_load_strobe_n, 3)) else $error("rollover");
  slow_loop_a: assert property (ok && !$past(host_in[1].slow_clock_select_n, 3)
    |-> !host_out[1].clock_align_enable) else $error("loop stays on");
  ready_hold_a: assert property (host_out[0].ready && ok |=>
    host_out[0].ready) else $error("ready dropped");
  drive_valid_a: assert property (!host_out[0].dq_oe_n |->
    host_out_rdata_valid) else $error("drive without valid data");
  cover property ($rose(host_out[0].busy));
  cover property ($fell(host_out[1].mailbox_flag_n));
  cover property ($fell(host_out[0].counter_rollover_flag_n));
endmodule : dpc_props
bind dpc_top dpc_props #(.ADDR_W(ADDR_W)) dpc_props_inst (
  .core_clk(core_clk), .nrst(nrst), .master_clear_n(master_clear_n),
  .host_in(host_in), .host_out_rdata_valid(host_out_rdata_valid),
  .host_out(host_out));
`default_nettype wire

// File: dpc_top.sv
// Dual-port 72-bit RAM with per-port burst counter, mailbox flags,
// collision busy, ready and flow-through or pipelined read path.
// Assumes both hosts are asynchronous to core_clk; all pins are resynced.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Byte enables gate each lane of access
// - Collision between ports raises busy on both
// - Select only when low enable low, high high
// - Data driven on reads only while output enable low
// - Top two addresses act as port mailboxes
// - Top is right mailbox, next is left
// - Foreign mailbox write drives owner flag low
// - Owner reading own mailbox returns flag high
// - Rollover flag low when unmasked bits reach ones
// - Wrap select low clears unmasked bits at max
// - Wrap select high reloads counter from mirror
// - Flow-through select off means pipelined output
// - Slow clock select disables clock alignment loop
// - Ready asserted once port can operate
// - Load address on its documented control pattern
// - Master clear zeroes counters, sets masks, flags
module dpc_top #(
  parameter int ADDR_W = dpc_pkg::ADDR_MAX
) (
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  input  wire logic                   master_clear_n,
  input  wire dpc_pkg::dpc_host_in_t  host_in  [dpc_pkg::PORTS],
  output logic                        host_out_rdata_valid,
  output dpc_pkg::dpc_host_out_t      host_out [dpc_pkg::PORTS]
);
  localparam int AM = dpc_pkg::ADDR_MAX;
  localparam int DW = dpc_pkg::DATA_W;
  localparam int LW = dpc_pkg::LANE_W;
  localparam int NL = dpc_pkg::LANES;
  localparam int HW = $bits(dpc_pkg::dpc_host_in_t);
  localparam logic [AM-1:0] ALIM = AM'((64'h1 << ADDR_W) - 64'h1);
  localparam logic [AM-1:0] ONE  = AM'(1);

  // Refuse address widths the array and mailbox decode cannot serve
  if (ADDR_W < 2 || ADDR_W > dpc_pkg::ADDR_MAX) begin : g_addr_chk
    $error("ADDR_W out of range");
  end

  // Resynchronised pins
  dpc_pkg::dpc_host_in_t hs [dpc_pkg::PORTS];
  logic                  mclr_n;
  logic [2*HW:0]         raw_in;
  logic [2*HW:0]         syn_in;
  logic [2*HW:0]         syn_inv;

  // Pins cross inverted so the cleared synchroniser reads as all ones:
  // port deselected, strobes off, loop on, no false master clear
  assign raw_in = ~{master_clear_n, host_in[1], host_in[0]};

  dpc_sync #(.W(2*HW+1)) dpc_sync_inst (
    .core_clk (core_clk),
    .nrst     (nrst),
    .async_in (raw_in),
    .sync_out (syn_inv)
  );

  assign syn_in = ~syn_inv;

  assign hs[0]  = syn_in[HW-1:0];
  assign hs[1]  = syn_in[2*HW-1:HW];
  assign mclr_n = syn_in[2*HW];

  // Storage array for the whole memory
  logic [DW-1:0] mem [2**ADDR_W];

  dpc_pkg::dpc_state_t st_q;
  dpc_pkg::dpc_state_t st_d;

  // Per-port access decode, driven by the state process
  logic [AM-1:0] acc   [dpc_pkg::PORTS];
  logic          sel   [dpc_pkg::PORTS];
  logic          wr_en [dpc_pkg::PORTS];
  logic          rd_en [dpc_pkg::PORTS];
  logic [NL-1:0] lanes [dpc_pkg::PORTS];

  // Next-state of both ports; counters, flags, read path
  always_comb begin
    logic [AM-1:0] c;
    logic [AM-1:0] nxt;
    logic [DW-1:0] rdv;
    logic          any_lane;
    logic          own_rd;
    logic          foreign_wr;
    logic [AM-1:0] top;
    logic [AM-1:0] own_box;
    int            o;
    c          = '0;
    nxt        = '0;
    rdv        = '0;
    any_lane   = 1'b0;
    own_rd     = 1'b0;
    foreign_wr = 1'b0;
    top        = ALIM;
    own_box    = '0;
    o          = 0;
    st_d       = st_q;
    for (int p = 0; p < dpc_pkg::PORTS; p++) begin
      c = st_q.p[p].cnt;
      // Select from both enables at this edge
      sel[p] = !hs[p].chip_select_low_active &&
               hs[p].chip_select_high_active;
      // Counter control decode
      if (!hs[p].counter_or_mask_select) begin
        if (!hs[p].address_load_strobe_n &&
            !hs[p].counter_advance_enable_n)
          st_d.p[p].mask = hs[p].addr & ALIM; // mask load
      end else if (!hs[p].counter_clear_n) begin
        c = c & ~st_q.p[p].mask; // counter reset, unmasked to zero
        st_d.p[p].roll_n = dpc_pkg::FLAG_IDLE;
      end else if (!hs[p].address_load_strobe_n &&
                   !hs[p].counter_advance_enable_n) begin
        c = hs[p].addr & ALIM;
        st_d.p[p].mirror = c;
        st_d.p[p].roll_n = dpc_pkg::FLAG_IDLE;
      end else if (hs[p].address_load_strobe_n &&
                   !hs[p].counter_advance_enable_n) begin
        if ((c & st_q.p[p].mask) == st_q.p[p].mask) begin
          if (hs[p].wrap_mode_select)
            c = st_q.p[p].mirror;
          else
            c = c & ~st_q.p[p].mask;
        end else begin
          // Carry ripples only through unmasked bits
          nxt = AM'((c | ~st_q.p[p].mask) + ONE);
          c   = (c & ~st_q.p[p].mask) | (nxt & st_q.p[p].mask);
          if ((c & st_q.p[p].mask) == st_q.p[p].mask)
            st_d.p[p].roll_n = 1'b0;
        end
      end
      st_d.p[p].cnt = c & ALIM;
      acc[p]   = c & ALIM;
      lanes[p] = ~hs[p].byte_lane_enable_n;
      any_lane = |lanes[p];
      wr_en[p] = sel[p] && !hs[p].read_not_write && any_lane;
      rd_en[p] = sel[p] && hs[p].read_not_write;
      // Read data, disabled lanes return zero
      for (int l = 0; l < NL; l++) begin
        rdv[l*LW +: LW] = lanes[p][l] ?
                          mem[acc[p][ADDR_W-1:0]][l*LW +: LW] :
                          LW'(0);
      end
      st_d.p[p].rd1     = rdv;
      st_d.p[p].rd1_vld = rd_en[p];
      // Flow-through skips the second read stage
      if (hs[p].flow_through_select) begin
        st_d.p[p].rout     = rdv;
        st_d.p[p].rout_vld = rd_en[p];
      end else begin
        st_d.p[p].rout     = st_q.p[p].rd1;
        st_d.p[p].rout_vld = st_q.p[p].rd1_vld;
      end
      // Drive only for valid read data and output enable low
      st_d.p[p].dq_oe_n = !(st_d.p[p].rout_vld &&
                            !hs[p].output_enable_n);
      st_d.p[p].align_en = hs[p].slow_clock_select_n;
      // Ready once alignment settles, or at once when loop is off
      if (!hs[p].slow_clock_select_n ||
          st_q.p[p].rdy_cnt == dpc_pkg::RDY_W'(dpc_pkg::READY_WAIT_CYC))
        st_d.p[p].ready = 1'b1;
      else
        st_d.p[p].rdy_cnt = st_q.p[p].rdy_cnt + dpc_pkg::RDY_W'(1);
    end
    // Mailbox flags; a set in the same cycle wins over a clear
    for (int p = 0; p < dpc_pkg::PORTS; p++) begin
      o = dpc_pkg::PORTS - 1 - p;
      own_box = (p == dpc_pkg::PORT_RIGHT) ?
                top - dpc_pkg::MBOX_RIGHT_OFS :
                top - dpc_pkg::MBOX_LEFT_OFS;
      own_rd     = rd_en[p] && |lanes[p] && acc[p] == own_box;
      foreign_wr = wr_en[o] && acc[o] == own_box;
      if (foreign_wr)
        st_d.p[p].mbox_n = 1'b0;
      else if (own_rd)
        st_d.p[p].mbox_n = 1'b1;
    end
    // Collision: same address, both selected, at least one writing
    for (int p = 0; p < dpc_pkg::PORTS; p++) begin
      st_d.p[p].busy = sel[0] && sel[1] && acc[0] == acc[1] &&
                       (wr_en[0] || wr_en[1]);
    end
    // Synchronous master clear, after the pin is resynced
    if (!mclr_n) begin
      for (int p = 0; p < dpc_pkg::PORTS; p++) begin
        st_d.p[p].cnt     = dpc_pkg::CNT_RST;
        st_d.p[p].mask    = dpc_pkg::MASK_RST & ALIM;
        st_d.p[p].mbox_n  = dpc_pkg::FLAG_IDLE;
        st_d.p[p].roll_n  = dpc_pkg::FLAG_IDLE;
        st_d.p[p].ready   = 1'b0;
        st_d.p[p].rdy_cnt = '0;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int p = 0; p < dpc_pkg::PORTS; p++) begin
        st_q.p[p]          <= '0;
        st_q.p[p].mask     <= dpc_pkg::MASK_RST & ALIM;
        st_q.p[p].mbox_n   <= dpc_pkg::FLAG_IDLE;
        st_q.p[p].roll_n   <= dpc_pkg::FLAG_IDLE;
        st_q.p[p].dq_oe_n  <= 1'b1;
        st_q.p[p].align_en <= 1'b1;
      end
    end else begin
      st_q <= st_d;
    end
  end

  // Array writes; right port wins a same-address double write
  always_ff @(posedge core_clk) begin
    for (int p = 0; p < dpc_pkg::PORTS; p++) begin
      for (int l = 0; l < NL; l++) begin
        if (wr_en[p] && lanes[p][l] && mclr_n)
          mem[acc[p][ADDR_W-1:0]][l*LW +: LW] <=
            hs[p].wdata[l*LW +: LW];
      end
    end
  end

  // Output mapping straight from state flops
  always_comb begin
    for (int p = 0; p < dpc_pkg::PORTS; p++) begin
      host_out[p].rdata                   = st_q.p[p].rout;
      host_out[p].dq_oe_n                 = st_q.p[p].dq_oe_n;
      host_out[p].busy                    = st_q.p[p].busy;
      host_out[p].mailbox_flag_n          = st_q.p[p].mbox_n;
      host_out[p].counter_rollover_flag_n = st_q.p[p].roll_n;
      host_out[p].ready                   = st_q.p[p].ready;
      host_out[p].clock_align_enable      = st_q.p[p].align_en;
    end
    host_out_rdata_valid = st_q.p[0].rout_vld | st_q.p[1].rout_vld;
  end
endmodule : dpc_top

`default_nettype wire

// File: test_dpc_top.sv
// Self-checking bench for the dual-port RAM port control, 8-bit address.
// Assumes results show three edges after a request, one more pipelined.
`timescale 1ns/1ps
`default_nettype none
module test_dpc_top;
  localparam logic [71:0] W1 = {8{9'h1c3}};
  localparam logic [71:0] W2 = {8{9'h0a5}};
  localparam logic [71:0] W3 = {8{9'h13c}};
  localparam logic [71:0] W4 = {8{9'h07e}};
  logic                   core_clk = 1'b0;
  logic                   nrst = 1'b0;
  logic                   master_clear_n = 1'b1;
  int                     err_total = 0;
  int                     total_checks = 0;
  dpc_pkg::dpc_host_in_t  hin [dpc_pkg::PORTS];
  dpc_pkg::dpc_host_out_t o [dpc_pkg::PORTS];
  dpc_pkg::dpc_host_in_t  v;
  logic                   rdv;
  always #4 core_clk = ~core_clk;
  dpc_host_model host_l (.core_clk(core_clk), .pins(hin[0]));
  dpc_host_model host_r (.core_clk(core_clk), .pins(hin[1]));
  dpc_top #(.ADDR_W(8)) dpc_top_inst (.core_clk(core_clk), .nrst(nrst),
    .master_clear_n(master_clear_n), .host_in(hin),
    .host_out_rdata_valid(rdv), .host_out(o));
  // Selected access; strobe arguments pick counter load, advance or hold
  function automatic dpc_pkg::dpc_host_in_t mk(logic rnw, logic [17:0] a,
      logic [7:0] be, logic [71:0] wd, logic address_load_strobe, logic adv);
    mk = '{addr: a, byte_lane_enable_n: be, read_not_write: rnw, wdata: wd,
      address_load_strobe_n: address_load_strobe, counter_advance_enable_n: adv,
      chip_select_low_active: 1'b0, output_enable_n: 1'b0, default: 1'b1};
  endfunction : mk
  task automatic chk(input string nm, input logic [71:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Issue one access and settle just after its result edge
  task automatic go(input int p, input dpc_pkg::dpc_host_in_t a);
    if (p == 0) host_l.req(a);
    else host_r.req(a);
    repeat (2) @(posedge core_clk);
    #1;
  endtask : go
  task automatic report_and_stop();
    if (err_total == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (60) @(posedge core_clk);
    #1 chk("ready early", o[0].ready, 1'b0);
    repeat (80) @(posedge core_clk);
    #1 chk("ready", o[0].ready, 1'b1);
    go(0, mk(1'b0, 18'hff, 8'hfe, W1, 1'b0, 1'b0));
    chk("right flag set", o[1].mailbox_flag_n, 1'b0);
    chk("left flag idle", o[0].mailbox_flag_n, 1'b1);
    chk("valid idle", rdv, 1'b0);
    for (int i = 0; i < 2; i++) begin
      v = mk(1'b0, 18'hfe, i ? 8'h00 : 8'hff, W2, 1'b0, 1'b0);
      v.chip_select_high_active = (i == 0);
      go(1, v);
      chk("refused write", o[0].mailbox_flag_n, 1'b1);
    end
    go(1, mk(1'b1, 18'hff, 8'hfe, W2, 1'b0, 1'b0));
    chk("lane read", o[1].rdata, {63'h0, W1[8:0]});
    chk("drive data", o[1].dq_oe_n, 1'b0);
    chk("read valid", rdv, 1'b1);
    chk("right flag clear", o[1].mailbox_flag_n, 1'b1);
    go(1, mk(1'b0, 18'hfe, 8'h00, W2, 1'b0, 1'b0));
    chk("left flag set", o[0].mailbox_flag_n, 1'b0);
    v = mk(1'b1, 18'hfe, 8'h00, W1, 1'b0, 1'b0);
    v.flow_through_select = 1'b0;
    go(0, v);
    chk("left flag clear", o[0].mailbox_flag_n, 1'b1);
    @(posedge core_clk);
    #1 chk("pipelined read", o[0].rdata, W2);
    v.output_enable_n = 1'b1;
    v.flow_through_select = 1'b1;
    go(0, v);
    chk("oe off", o[0].dq_oe_n, 1'b1);
    go(0, mk(1'b0, 18'h00, 8'h00, W3, 1'b0, 1'b0));
    go(0, mk(1'b0, 18'hfd, 8'h00, W4, 1'b0, 1'b0));
    for (int w = 0; w < 2; w++) begin
      go(0, mk(1'b1, 18'hfd, 8'h00, W1, 1'b0, 1'b0));
      chk("load read", o[0].rdata, W4);
      chk("load flag", o[0].counter_rollover_flag_n, 1'b1);
      v = mk(1'b1, 18'h00, 8'h00, W1, 1'b1, 1'b0);
      v.wrap_mode_select = w[0];
      go(0, v);
      go(0, v);
      chk("rollover", o[0].counter_rollover_flag_n, 1'b0);
      go(0, v);
      chk("wrap read", o[0].rdata, w ? W4 : W3);
    end
    fork
      go(0, mk(1'b0, 18'h40, 8'h00, W1, 1'b0, 1'b0));
      go(1, mk(1'b1, 18'h40, 8'h00, W1, 1'b0, 1'b0));
    join
    chk("busy left", o[0].busy, 1'b1);
    chk("busy right", o[1].busy, 1'b1);
    v = mk(1'b1, 18'h40, 8'hff, W1, 1'b1, 1'b1);
    v.slow_clock_select_n = 1'b0;
    go(1, v);
    chk("loop off", o[1].clock_align_enable, 1'b0);
    chk("other loop on", o[0].clock_align_enable, 1'b1);
    go(0, mk(1'b0, 18'hff, 8'hfe, W1, 1'b0, 1'b0));
    chk("flag before clear", o[1].mailbox_flag_n, 1'b0);
    @(posedge core_clk);
    master_clear_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    master_clear_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 chk("clear flag", o[1].mailbox_flag_n, 1'b1);
    chk("clear ready", o[0].ready, 1'b0);
    report_and_stop();
  end
endmodule : test_dpc_top
`default_nettype wire
